// ### rtl/wake_event_pkg.sv
// package of register offsets, field positions, reset values and timing
// assumes a single 100 MHz clock domain shared by all users
package wake_event_pkg;

    localparam logic [6:0] sys_enable_addr = 7'h04;
    localparam logic [6:0] trx_enable_addr = 7'h23;
    localparam logic [6:0] wake_enable_addr = 7'h4c;
    localparam logic [6:0] summary_addr = 7'h60;
    localparam logic [6:0] sys_flags_addr = 7'h61;
    localparam logic [6:0] trx_flags_addr = 7'h63;
    localparam logic [6:0] wake_flags_addr = 7'h64;

    // summary register bits
    localparam int sum_sys_bit = 0;
    localparam int sum_trx_bit = 2;
    localparam int sum_wake_bit = 3;

    // system flags / enables
    localparam int startup_bit = 4;
    localparam int overheat_bit = 2;
    localparam int serial_fault_bit = 1;
    localparam logic [7:0] sys_flag_mask = 8'h16;
    localparam logic [7:0] sys_enable_mask = 8'h06;

    // transceiver flags / enables
    localparam int frame_err_bit = 5;
    localparam int silence_bit = 4;
    localparam int bus_fail_bit = 1;
    localparam int bus_wake_bit = 0;
    localparam logic [7:0] trx_flag_mask = 8'h33;
    localparam logic [7:0] trx_enable_mask = 8'h13;

    // wake pin flags / enables
    localparam int rise_bit = 1;
    localparam int fall_bit = 0;
    localparam logic [7:0] wake_mask = 8'h03;

    localparam logic [7:0] enable_reset = 8'h00;
    localparam logic [7:0] flags_reset = 8'h00;

    // transceiver mode field value that arms the supply undervoltage failure
    localparam logic [1:0] trx_mode_active_uv = 2'b01;

    // event delay timer
    localparam int clk_period_ns = 10;
    localparam int event_delay_us = 1;
    localparam int event_delay_cycles = (event_delay_us * 1000) / clk_period_ns;

    typedef struct packed {
        logic overheat;
        logic serial_fault;
        logic frame_error;
        logic bus_silence;
        logic txd_clamped;
        logic supply_uv;
        logic bus_wake;
        logic wake_pin;
    } event_in_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : wake_event_pkg

// ### rtl/event_delay_timer.sv
// delay timer that holds off the receive-pin event signal
// assumes restart pulses and clock enable on ref_clk
`timescale 1ns/100ps
module event_delay_timer
    import wake_event_pkg::*;
#(
    parameter int delay_cycles = event_delay_cycles
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic restart,
    output logic running
);
    localparam int cw = $clog2(delay_cycles + 1);

    logic [cw-1:0] count_ff;

    if (delay_cycles < 1)
    begin : g_bad_delay
        $error("delay_cycles must be at least one");
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            count_ff <= '0;
        else if (clk_en)
        begin
            if (restart)
                count_ff <= cw'(delay_cycles);
            else if (count_ff != '0)
                count_ff <= count_ff - 1'b1;
        end
    end

    assign running = (count_ff != '0);

endmodule : event_delay_timer

// ### rtl/wake_event_status_capture.sv
// event capture, event status flags, global summary and receive-pin signal
// assumes a byte register port fed by the serial front end on ref_clk;
// event inputs are single-cycle or level detections synchronous to ref_clk
`timescale 1ns/100ps
module wake_event_status_capture
    import wake_event_pkg::*;
#(
    parameter int delay_cycles = event_delay_cycles
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire event_in_t events,
    input wire logic startup_done,
    input wire logic uv_forced_sleep,
    input wire logic normal_mode,
    input wire logic trx_active,
    input wire logic [1:0] transceiver_mode_field,
    input wire logic trx_offline,
    input wire logic wake_pin_level,
    output logic rxd_event_n,
    output logic [7:0] summary_ff
);
    logic [7:0] sys_en_ff;
    logic [7:0] trx_en_ff;
    logic [7:0] wake_en_ff;
    logic [7:0] sys_flags_ff;
    logic [7:0] trx_flags_ff;
    logic [7:0] wake_flags_ff;
    logic wake_pin_ff;
    logic wake_pin_seen_ff;
    logic startup_seen_ff;
    logic [7:0] sys_set;
    logic [7:0] trx_set;
    logic [7:0] wake_set;
    logic [7:0] sys_clr;
    logic [7:0] trx_clr;
    logic [7:0] wake_clr;
    logic [7:0] nxt_sys_flags;
    logic [7:0] nxt_trx_flags;
    logic [7:0] nxt_wake_flags;
    logic [7:0] nxt_summary;
    logic [7:0] nxt_rdata;
    logic any_clear;
    logic any_pending;
    logic timer_running;
    logic startup_pulse;
    logic bus_fail_event;
    logic wake_rise;
    logic wake_fall;

    if (delay_cycles < 1)
    begin : g_bad_delay
        $error("delay_cycles must be at least one");
    end

    // enable registers
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sys_en_ff <= enable_reset;
            trx_en_ff <= enable_reset;
            wake_en_ff <= enable_reset;
        end
        else if (clk_en && reg_req.wr)
        begin
            if (reg_req.addr == sys_enable_addr)
                sys_en_ff <= reg_req.wdata & sys_enable_mask;
            else if (reg_req.addr == trx_enable_addr)
                trx_en_ff <= reg_req.wdata & trx_enable_mask;
            else if (reg_req.addr == wake_enable_addr)
                wake_en_ff <= reg_req.wdata & wake_mask;
        end
    end

    // wake pin edge detection and one-shot startup marker
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            wake_pin_ff <= 1'b0;
            wake_pin_seen_ff <= 1'b0;
            startup_seen_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_pin_ff <= wake_pin_level;
            wake_pin_seen_ff <= 1'b1;
            if (startup_done)
                startup_seen_ff <= 1'b1;
        end
    end

    assign startup_pulse = startup_done && !startup_seen_ff;
    assign wake_rise = wake_pin_seen_ff && wake_pin_level && !wake_pin_ff;
    assign wake_fall = wake_pin_seen_ff && !wake_pin_level && wake_pin_ff;
    assign bus_fail_event = normal_mode && trx_active && (events.txd_clamped
        || (events.supply_uv && transceiver_mode_field == trx_mode_active_uv));

    always_comb
    begin
        sys_set = 8'h00;
        trx_set = 8'h00;
        wake_set = 8'h00;
        sys_set[startup_bit] = startup_pulse;
        sys_set[overheat_bit] = events.overheat && sys_en_ff[overheat_bit];
        sys_set[serial_fault_bit] = events.serial_fault
            && sys_en_ff[serial_fault_bit];
        trx_set[frame_err_bit] = events.frame_error;
        trx_set[silence_bit] = events.bus_silence && trx_en_ff[silence_bit];
        trx_set[bus_fail_bit] = bus_fail_event && trx_en_ff[bus_fail_bit];
        trx_set[bus_wake_bit] = events.bus_wake && trx_en_ff[bus_wake_bit];
        wake_set[rise_bit] = wake_rise && wake_en_ff[rise_bit];
        wake_set[fall_bit] = wake_fall && wake_en_ff[fall_bit];
    end

    always_comb
    begin
        sys_clr = 8'h00;
        trx_clr = 8'h00;
        wake_clr = 8'h00;
        if (reg_req.wr)
        begin
            if (reg_req.addr == sys_flags_addr)
                sys_clr = reg_req.wdata & sys_flag_mask;
            else if (reg_req.addr == trx_flags_addr)
                trx_clr = reg_req.wdata & trx_flag_mask;
            else if (reg_req.addr == wake_flags_addr)
                wake_clr = reg_req.wdata & wake_mask;
        end
    end

    // set wins over a written clear in the same cycle; forced sleep clears all flags over both
    always_comb
    begin
        nxt_sys_flags = ((sys_flags_ff & ~sys_clr) | sys_set) & sys_flag_mask;
        nxt_trx_flags = ((trx_flags_ff & ~trx_clr) | trx_set) & trx_flag_mask;
        nxt_wake_flags = ((wake_flags_ff & ~wake_clr) | wake_set) & wake_mask;
        if (uv_forced_sleep)
        begin
            nxt_sys_flags = 8'h00;
            nxt_trx_flags = 8'h00;
            nxt_wake_flags = 8'h00;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sys_flags_ff <= flags_reset;
            trx_flags_ff <= flags_reset;
            wake_flags_ff <= flags_reset;
        end
        else if (clk_en)
        begin
            sys_flags_ff <= nxt_sys_flags;
            trx_flags_ff <= nxt_trx_flags;
            wake_flags_ff <= nxt_wake_flags;
        end
    end

    // summary follows the flag registers; registered copy for the port
    always_comb
    begin
        nxt_summary = 8'h00;
        nxt_summary[sum_sys_bit] = |sys_flags_ff;
        nxt_summary[sum_trx_bit] = |trx_flags_ff;
        nxt_summary[sum_wake_bit] = |wake_flags_ff;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            summary_ff <= 8'h00;
        else if (clk_en)
            summary_ff <= {nxt_summary[7:4], nxt_summary[3:0]};
    end

    // register read data, unmapped addresses read zero
    always_comb
    begin
        if (reg_req.addr == sys_enable_addr)
            nxt_rdata = sys_en_ff;
        else if (reg_req.addr == trx_enable_addr)
            nxt_rdata = trx_en_ff;
        else if (reg_req.addr == wake_enable_addr)
            nxt_rdata = wake_en_ff;
        else if (reg_req.addr == summary_addr)
            nxt_rdata = nxt_summary;
        else if (reg_req.addr == sys_flags_addr)
            nxt_rdata = sys_flags_ff;
        else if (reg_req.addr == trx_flags_addr)
            nxt_rdata = trx_flags_ff;
        else if (reg_req.addr == wake_flags_addr)
            nxt_rdata = wake_flags_ff;
        else
            nxt_rdata = 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_req.rd)
            reg_rdata <= nxt_rdata;
    end

    // receive pin event signalling with hold-off timer
    assign any_clear = clk_en && (|(sys_clr & sys_flags_ff)
        || |(trx_clr & trx_flags_ff) || |(wake_clr & wake_flags_ff));
    assign any_pending = |nxt_sys_flags || |nxt_trx_flags || |nxt_wake_flags;

    event_delay_timer #(
        .delay_cycles(delay_cycles)
    ) u_delay (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .restart(any_clear),
        .running(timer_running)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            rxd_event_n <= 1'b1;
        else if (clk_en)
        begin
            if (any_clear || timer_running)
                rxd_event_n <= 1'b1;
            else
                rxd_event_n <= !(trx_offline && any_pending);
        end
    end

    a_clear_takes: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && reg_req.wr && reg_req.addr == wake_flags_addr
        && reg_req.wdata[fall_bit] && !wake_set[fall_bit]
        |=> !wake_flags_ff[fall_bit])
        else $error("written one did not clear flag");
    a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && reg_req.wr && reg_req.addr == sys_flags_addr
        && !reg_req.wdata[overheat_bit] && sys_flags_ff[overheat_bit]
        && !uv_forced_sleep |=> sys_flags_ff[overheat_bit])
        else $error("written zero changed a flag");
    a_wake_summary: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> summary_ff[sum_wake_bit] == $past(|wake_flags_ff))
        else $error("wake summary mismatch");
    a_trx_summary: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> summary_ff[sum_trx_bit] == $past(|trx_flags_ff))
        else $error("transceiver summary mismatch");
    a_sys_summary: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en |=> summary_ff[sum_sys_bit] == $past(|sys_flags_ff))
        else $error("system summary mismatch");
    a_sum_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
        summary_ff[7:4] == 4'h0 && !summary_ff[1])
        else $error("summary reserved bits set");
    a_startup_once: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && startup_done && !startup_seen_ff && !uv_forced_sleep
        |=> sys_flags_ff[startup_bit])
        else $error("startup flag not set");
    a_uv_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && uv_forced_sleep |=> !sys_flags_ff[startup_bit])
        else $error("startup flag survived forced sleep");
    a_overheat_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && events.overheat && sys_en_ff[overheat_bit] && !uv_forced_sleep
        |=> sys_flags_ff[overheat_bit])
        else $error("overheat warning not captured");
    a_serial_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && events.serial_fault && sys_en_ff[serial_fault_bit] && !uv_forced_sleep
        |=> sys_flags_ff[serial_fault_bit])
        else $error("serial fault not captured");
    a_flag_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sys_flags_ff & ~sys_flag_mask) == 8'h00
        && (trx_flags_ff & ~trx_flag_mask) == 8'h00
        && (wake_flags_ff & ~wake_mask) == 8'h00)
        else $error("reserved flag bit set");
    a_silence_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && events.bus_silence && trx_en_ff[silence_bit] && !uv_forced_sleep
        |=> trx_flags_ff[silence_bit])
        else $error("bus silence not captured");
    a_bus_fail_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !(normal_mode && trx_active) && !trx_flags_ff[bus_fail_bit]
        |=> !trx_flags_ff[bus_fail_bit])
        else $error("bus failure captured outside normal active mode");
    a_bus_wake_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && events.bus_wake && trx_en_ff[bus_wake_bit] && !uv_forced_sleep
        |=> trx_flags_ff[bus_wake_bit])
        else $error("bus wake-up not captured");
    a_rise_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wake_pin_seen_ff && wake_pin_level && !wake_pin_ff
        && wake_en_ff[rise_bit] && !uv_forced_sleep
        |=> wake_flags_ff[rise_bit])
        else $error("wake pin rising edge not captured");
    a_fall_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && wake_pin_seen_ff && !wake_pin_level && wake_pin_ff
        && wake_en_ff[fall_bit] && !uv_forced_sleep
        |=> wake_flags_ff[fall_bit])
        else $error("wake pin falling edge not captured");
    a_enable_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sys_en_ff & ~sys_enable_mask) == 8'h00
        && (trx_en_ff & ~trx_enable_mask) == 8'h00
        && (wake_en_ff & ~wake_mask) == 8'h00)
        else $error("reserved enable bit set");
    a_enable_gates: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !trx_en_ff[silence_bit] && !trx_flags_ff[silence_bit]
        |=> !trx_flags_ff[silence_bit])
        else $error("disabled event captured");
    a_frame_always: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && events.frame_error && !uv_forced_sleep
        |=> trx_flags_ff[frame_err_bit])
        else $error("frame error not captured");
    a_event_signal: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && trx_offline && !any_clear && !timer_running && any_pending
        |=> !rxd_event_n)
        else $error("pending event not signalled");
    a_idle_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && !trx_offline |=> rxd_event_n)
        else $error("receive pin low while online");
    a_clear_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        any_clear |=> rxd_event_n ##1 rxd_event_n)
        else $error("receive pin not released after clear");
    a_timer_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        timer_running |=> rxd_event_n)
        else $error("receive pin low while delay timer runs");

endmodule : wake_event_status_capture

// ### sim/mcu_model.sv
// microcontroller side: one-byte register accesses on the register port
// assumes the core takes a request at a rising ref_clk with clk_en high
`timescale 1ns/100ps
module mcu_model
    import wake_event_pkg::*;
(
    input wire logic ref_clk,
    output reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 7'h2a, wdata: 8'h5a};

    // idle port shows inverted leftovers, never the last address or data
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge ref_clk);
        #1 reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 q = reg_rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : mcu_model

// ### sim/tb.sv
// self-checking bench: register model compared at every read
// assumes a 100 MHz ref_clk and a shortened event delay timer
`timescale 1ns/100ps
module tb
    import wake_event_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    event_in_t events = '0;
    logic startup_done = 1'b0;
    logic uv_sleep = 1'b0;
    logic normal_mode = 1'b1;
    logic trx_active = 1'b1;
    logic [1:0] mode = 2'b01;
    logic offline = 1'b1;
    logic wpin = 1'b0;
    reg_req_t reg_req;
    logic [7:0] rdata;
    logic rxd_n;
    logic [7:0] summ;
    logic [7:0] q;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] en [3];
    logic [7:0] fl [3];
    localparam logic [6:0] en_a [3] = '{sys_enable_addr, trx_enable_addr, wake_enable_addr};
    localparam logic [6:0] fl_a [3] = '{sys_flags_addr, trx_flags_addr, wake_flags_addr};
    localparam logic [7:0] en_m [3] = '{sys_enable_mask, trx_enable_mask, wake_mask};
    localparam int sim_delay = 4;

    always #5 ref_clk = ~ref_clk;

    wake_event_status_capture #(.delay_cycles(sim_delay)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata(rdata), .events(events), .startup_done(startup_done),
        .uv_forced_sleep(uv_sleep), .normal_mode(normal_mode), .trx_active(trx_active),
        .transceiver_mode_field(mode), .trx_offline(offline), .wake_pin_level(wpin),
        .rxd_event_n(rxd_n), .summary_ff(summ));

    mcu_model mcu (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(rdata));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for the receive pin level
    task automatic chk_rxd(input logic exp, input int lim);
        int i;
        i = 0;
        while (rxd_n !== exp && i < lim)
        begin
            @(posedge ref_clk);
            #1 i++;
        end
        n_tests++;
        if (rxd_n !== exp)
        begin
            miscompares++;
            $display("BAD %0t receive pin %b", $time, rxd_n);
        end
    endtask : chk_rxd

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        mcu.access(1'b0, a, 8'h00, q);
        chk(exp, q);
    endtask : rd_chk

    task automatic set_en(input int k, input logic [7:0] d);
        mcu.access(1'b1, en_a[k], d, q);
        en[k] = d & en_m[k];
    endtask : set_en

    task automatic clr(input int k, input logic [7:0] d);
        mcu.access(1'b1, fl_a[k], d, q);
        fl[k] = fl[k] & ~d;
    endtask : clr

    task automatic check_all();
        for (int k = 0; k < 3; k++)
        begin
            rd_chk(en_a[k], en[k]);
            rd_chk(fl_a[k], fl[k]);
        end
        rd_chk(summary_addr, {4'h0, |fl[2], |fl[1], 1'b0, |fl[0]});
        chk({4'h0, |fl[2], |fl[1], 1'b0, |fl[0]}, summ);
        rd_chk(7'h10, 8'h00);
    endtask : check_all

    task automatic pulse(input event_in_t e, input logic ce);
        @(posedge ref_clk);
        #1 events = e;
        clk_en = ce;
        @(posedge ref_clk);
        #1 events = '0;
        clk_en = 1'b1;
        if (ce)
        begin
            fl[0] |= {3'h0, 2'h0, e.overheat & en[0][2], e.serial_fault & en[0][1], 1'b0};
            fl[1] |= {2'h0, e.frame_error, e.bus_silence & en[1][4], 2'h0,
                (e.txd_clamped | (e.supply_uv & (mode == 2'b01)))
                & normal_mode & trx_active & en[1][1], e.bus_wake & en[1][0]};
        end
    endtask : pulse

    task automatic wake(input logic v);
        @(posedge ref_clk);
        fl[2] |= {6'h0, v & !wpin & en[2][1], !v & wpin & en[2][0]};
        #1 wpin = v;
        repeat (3) @(posedge ref_clk);
    endtask : wake

    initial
    begin
        #900000;
        miscompares++;
        $display("BAD %0t run did not finish", $time);
        end_of_test();
    end

    initial
    begin
        event_in_t e;
        void'($urandom(32'h2f64d5b5));
        en = '{default: 8'h00};
        fl = '{default: 8'h00};
        repeat (8) @(posedge ref_clk);
        #1 rstn = 1'b1;
        mcu.access(1'b1, 7'h10, 8'hff, q);
        check_all();
        chk_rxd(1'b1, 0);
        startup_done = 1'b1;
        fl[0][startup_bit] = 1'b1;
        chk_rxd(1'b0, 10);
        check_all();
        for (int k = 0; k < 3; k++)
            set_en(k, 8'hff);
        pulse('1, 1'b1);
        wake(1'b1);
        check_all();
        clr(1, 8'h01);
        chk_rxd(1'b1, 0);
        repeat (sim_delay - 1) @(posedge ref_clk);
        #1 chk_rxd(1'b1, 0);
        chk_rxd(1'b0, 2);
        check_all();
        for (int k = 0; k < 3; k++)
            clr(k, 8'hff);
        repeat (10) @(posedge ref_clk);
        chk_rxd(1'b1, 0);
        pulse('1, 1'b1);
        @(posedge ref_clk);
        #1 uv_sleep = 1'b1;
        @(posedge ref_clk);
        #1 uv_sleep = 1'b0;
        fl = '{default: 8'h00};
        check_all();
        for (int k = 0; k < 3; k++)
            set_en(k, 8'h00);
        pulse('1, 1'b1);
        wake(1'b0);
        check_all();
        clr(1, 8'hff);
        for (int k = 0; k < 3; k++)
            set_en(k, 8'hff);
        pulse('1, 1'b0);
        check_all();
        set_en(1, 8'h02);
        for (int i = 0; i < 16; i++)
        begin
            normal_mode = i[0];
            trx_active = i[1];
            mode = i[2] ? 2'b01 : 2'b10;
            e = '0;
            e.txd_clamped = !i[3];
            e.supply_uv = i[3];
            pulse(e, 1'b1);
            rd_chk(trx_flags_addr, fl[1]);
            clr(1, 8'hff);
        end
        normal_mode = 1'b1;
        trx_active = 1'b1;
        mode = 2'b01;
        repeat (20)
        begin
            for (int k = 0; k < 3; k++)
                set_en(k, 8'($urandom));
            pulse(event_in_t'(8'($urandom)), 1'b1);
            wake(!wpin);
            check_all();
            for (int k = 0; k < 3; k++)
                clr(k, 8'($urandom));
            check_all();
        end
        @(posedge ref_clk);
        #1 rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rstn = 1'b1;
        en = '{default: 8'h00};
        fl = '{default: 8'h00};
        fl[0][startup_bit] = 1'b1;
        check_all();
        pulse('1, 1'b1);
        chk_rxd(1'b0, 10);
        offline = 1'b0;
        chk_rxd(1'b1, 10);
        end_of_test();
    end
endmodule : tb
